//--- src/jtag_chain_defs.svh
`ifndef JTAG_CHAIN_DEFS_SVH
`define JTAG_CHAIN_DEFS_SVH

// Clock rates in whole MHz
`define SYS_CLK_MHZ 12'h032
`define TCK_DEFAULT_MHZ 6'h04
`define TCK_MAX_MHZ 6'h06
`define MHZ_W 6

// Counter and field widths
`define CNT_W 10
`define HALF_W 5

// TMS paths, first bit in bit 0
`define TLR_BITS 3'h5
`define HEAD_IR_TMS 4'h3
`define HEAD_IR_LEN 3'h4
`define HEAD_DR_TMS 4'h1
`define HEAD_DR_LEN 3'h3

// Chain analysis
`define FLUSH_BITS 10'h100
`define ANALYSE_BITS 10'h200

// Padding bit values
`define IR_PAD_BIT 1'b1
`define DR_PAD_BIT 1'b0

`endif

//--- src/jtag_chain_pkg.sv
package jtag_chain_pkg;

	// Scan kinds; the analysis kinds run back to back
	typedef enum logic [1:0] {
		KIND_IR = 2'h0,
		KIND_DR = 2'h1,
		KIND_AIR = 2'h2,
		KIND_ADR = 2'h3
	} scan_kind_t;

	// Sequencer states, Gray coded along the scan path
	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_IDLE = 3'h1,
		ST_HEAD = 3'h3,
		ST_SHIFT = 3'h2,
		ST_EXIT = 3'h6,
		ST_UPDATE = 3'h7
	} tap_seq_t;

endpackage

//--- src/chain_cfg_if.sv
`timescale 1ns/10ps
`include "jtag_chain_defs.svh"

interface chain_cfg_if;
	logic [`CNT_W-1:0] preIr;
	logic [`CNT_W-1:0] postIr;
	logic [`CNT_W-1:0] preDr;
	logic [`CNT_W-1:0] postDr;
	logic [`HALF_W-1:0] tckHalf;
	logic [`CNT_W-1:0] autoDevices;
	logic autoValid;

	modport calc (
		input autoDevices,
		input autoValid,
		output preIr,
		output postIr,
		output preDr,
		output postDr,
		output tckHalf
	);

	modport engine (
		output autoDevices,
		output autoValid,
		input preIr,
		input postIr,
		input preDr,
		input postDr,
		input tckHalf
	);
endinterface

//--- src/pad_rate_calc.sv
`timescale 1ns/10ps
`include "jtag_chain_defs.svh"

module pad_rate_calc
	import jtag_chain_pkg::*;
#(
	parameter int MAX_DEV = 8,
	localparam int IDX_W = $clog2(MAX_DEV + 1)
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic chainDescValid,
	input wire logic [IDX_W-1:0] devCount,
	input wire logic [MAX_DEV-1:0][7:0] irLen,
	input wire logic [IDX_W-1:0] targetIdx,
	input wire logic fileValid,
	input wire logic [MAX_DEV-1:0][`MHZ_W-1:0] freqStmt,
	input wire logic [MAX_DEV-1:0][`MHZ_W-1:0] maxFreqNote,
	input wire logic [MAX_DEV-1:0] devTargeted,
	input wire logic forceTck,
	input wire logic [`MHZ_W-1:0] forcedMhz,
	input wire logic [`CNT_W-1:0] opPreIr,
	input wire logic [`CNT_W-1:0] opPostIr,
	chain_cfg_if.calc cfg
);

	// Smallest half period in system clocks that keeps TCK at or below mhz
	function automatic logic [`HALF_W-1:0] halfCycles(input logic [`MHZ_W-1:0] mhz);
		logic [`HALF_W-1:0] k;
		k = '1;
		for (int j = 31; j >= 1; j--) begin
			if (12'(j) * 12'(mhz) * 12'h002 >= `SYS_CLK_MHZ) begin
				k = `HALF_W'(j);
			end
		end
		return k;
	endfunction

	logic [`CNT_W-1:0] next_preIr;
	logic [`CNT_W-1:0] next_postIr;
	logic [`CNT_W-1:0] next_preDr;
	logic [`CNT_W-1:0] next_postDr;
	logic [`HALF_W-1:0] next_tckHalf;
	logic [`MHZ_W-1:0] rate;
	logic [`CNT_W-1:0] chainLen;

	// IR padding from chain description or opPreIr/opPostIr, DR padding from description or analysis; TCK rate from force, file or description
	always_comb begin
		next_preIr = '0;
		next_postIr = '0;
		next_preDr = '0;
		next_postDr = '0;
		chainLen = chainDescValid ? `CNT_W'(devCount) : cfg.autoDevices;
		for (int i = 0; i < MAX_DEV; i++) begin
			if (IDX_W'(i) < devCount) begin
				if (IDX_W'(i) < targetIdx) begin
					next_preIr = next_preIr + `CNT_W'(irLen[i]);
				end else if (IDX_W'(i) > targetIdx) begin
					next_postIr = next_postIr + `CNT_W'(irLen[i]);
				end
			end
		end
		if (!chainDescValid) begin
			next_preIr = opPreIr;
			next_postIr = opPostIr;
		end
		if (chainDescValid || cfg.autoValid) begin
			if (chainLen > `CNT_W'(targetIdx)) begin
				next_preDr = `CNT_W'(targetIdx);
				next_postDr = chainLen - `CNT_W'(targetIdx) - `CNT_W'(1);
			end
		end
		rate = `TCK_DEFAULT_MHZ;
		if (forceTck) begin
			rate = forcedMhz;
		end else if (fileValid || chainDescValid) begin
			rate = '1;
			for (int i = 0; i < MAX_DEV; i++) begin
				if (devTargeted[i] && freqStmt[i] != '0 && freqStmt[i] < rate) begin
					rate = freqStmt[i];
				end
				if (devTargeted[i] && maxFreqNote[i] != '0 && maxFreqNote[i] < rate) begin
					rate = maxFreqNote[i];
				end
			end
		end
		if (rate > `TCK_MAX_MHZ) begin
			rate = `TCK_MAX_MHZ;
		end
		if (rate == '0) begin
			rate = `MHZ_W'(1);
		end
		next_tckHalf = halfCycles(rate);
	end

	// Register the results toward the sequencer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg.preIr <= '0;
			cfg.postIr <= '0;
			cfg.preDr <= '0;
			cfg.postDr <= '0;
			cfg.tckHalf <= halfCycles(`TCK_DEFAULT_MHZ);
		end else begin
			cfg.preIr <= next_preIr;
			cfg.postIr <= next_postIr;
			cfg.preDr <= next_preDr;
			cfg.postDr <= next_postDr;
			cfg.tckHalf <= next_tckHalf;
		end
	end

endmodule

//--- src/jtag_chain_ctrl.sv
`timescale 1ns/10ps
`include "jtag_chain_defs.svh"


module jtag_chain_ctrl
	import jtag_chain_pkg::*;
#(
	parameter int MAX_DEV = 8,
	parameter int MAX_DR = 64,
	localparam int IDX_W = $clog2(MAX_DEV + 1)
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic cmdValid,
	input wire scan_kind_t cmdKind,
	input wire logic [MAX_DR-1:0] cmdData,
	input wire logic [`CNT_W-1:0] cmdLen,
	output logic cmdReady,
	output logic respValid,
	output logic [MAX_DR-1:0] respData,
	input wire logic chainDescValid,
	input wire logic [IDX_W-1:0] devCount,
	input wire logic [MAX_DEV-1:0][7:0] irLen,
	input wire logic [IDX_W-1:0] targetIdx,
	input wire logic fileValid,
	input wire logic [MAX_DEV-1:0][`MHZ_W-1:0] freqStmt,
	input wire logic [MAX_DEV-1:0][`MHZ_W-1:0] maxFreqNote,
	input wire logic [MAX_DEV-1:0] devTargeted,
	input wire logic forceTck,
	input wire logic [`MHZ_W-1:0] forcedMhz,
	input wire logic [`CNT_W-1:0] opPreIr,
	input wire logic [`CNT_W-1:0] opPostIr,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	output logic [`CNT_W-1:0] chainDevices,
	output logic [`CNT_W-1:0] chainIrTotal,
	output logic analyseOk
);

	// TMS path from Run-Test/Idle into the shift state
	function automatic logic [3:0] headTms(input scan_kind_t k);
		return (k == KIND_IR || k == KIND_AIR) ? `HEAD_IR_TMS : `HEAD_DR_TMS;
	endfunction

	function automatic logic [2:0] headLen(input scan_kind_t k);
		return (k == KIND_IR || k == KIND_AIR) ? `HEAD_IR_LEN : `HEAD_DR_LEN;
	endfunction

	chain_cfg_if cfg();

	pad_rate_calc #(
		.MAX_DEV(MAX_DEV)
	) calc (
		.sys_clk(sys_clk),
		.srst(srst),
		.chainDescValid(chainDescValid),
		.devCount(devCount),
		.irLen(irLen),
		.targetIdx(targetIdx),
		.fileValid(fileValid),
		.freqStmt(freqStmt),
		.maxFreqNote(maxFreqNote),
		.devTargeted(devTargeted),
		.forceTck(forceTck),
		.forcedMhz(forcedMhz),
		.opPreIr(opPreIr),
		.opPostIr(opPostIr),
		.cfg(cfg.calc)
	);

	// Returning TDO: three flops, accepted when the last two agree
	logic tdoS1;
	logic tdoS2;
	logic tdoS3;
	logic tdoIn;
	logic next_tdoIn;

	always_comb begin
		next_tdoIn = (tdoS2 == tdoS3) ? tdoS3 : tdoIn;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tdoS1 <= 1'b0;
			tdoS2 <= 1'b0;
			tdoS3 <= 1'b0;
			tdoIn <= 1'b0;
		end else begin
			tdoS1 <= tdo;
			tdoS2 <= tdoS1;
			tdoS3 <= tdoS2;
			tdoIn <= next_tdoIn;
		end
	end

	// TCK divider, free running at the selected rate
	logic [`HALF_W-1:0] div;
	logic [`HALF_W-1:0] next_div;
	logic next_tck;
	logic tckRise;
	logic tckFall;

	always_comb begin
		next_tck = tck;
		tckRise = 1'b0;
		tckFall = 1'b0;
		if (div == '0) begin
			next_div = cfg.tckHalf - `HALF_W'(1);
			next_tck = ~tck;
			tckRise = ~tck;
			tckFall = tck;
		end else begin
			next_div = div - `HALF_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div <= '0;
			tck <= 1'b0;
		end else begin
			div <= next_div;
			tck <= next_tck;
		end
	end

	// Scan sequencer state
	tap_seq_t state;
	tap_seq_t next_state;
	scan_kind_t kind;
	scan_kind_t next_kind;
	logic [2:0] hdrCnt;
	logic [2:0] next_hdrCnt;
	logic [`CNT_W-1:0] pos;
	logic [`CNT_W-1:0] next_pos;
	logic [`CNT_W-1:0] pre;
	logic [`CNT_W-1:0] next_pre;
	logic [`CNT_W-1:0] tgtEnd;
	logic [`CNT_W-1:0] next_tgtEnd;
	logic [`CNT_W-1:0] total;
	logic [`CNT_W-1:0] next_total;
	logic [`CNT_W-1:0] len;
	logic [`CNT_W-1:0] next_len;
	logic [`CNT_W-1:0] measCnt;
	logic [`CNT_W-1:0] next_measCnt;
	logic [MAX_DR-1:0] txReg;
	logic [MAX_DR-1:0] next_txReg;
	logic [MAX_DR-1:0] rxReg;
	logic [MAX_DR-1:0] next_rxReg;
	logic found;
	logic next_found;
	logic next_tms;
	logic next_tdi;
	logic next_cmdReady;
	logic next_respValid;
	logic [MAX_DR-1:0] next_respData;
	logic [`CNT_W-1:0] next_chainDevices;
	logic [`CNT_W-1:0] next_chainIrTotal;
	logic next_analyseOk;
	logic inTarget;
	logic nextInTarget;
	logic userScan;

	// Next state of the scan engine; TAP moves on rising TCK
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_hdrCnt = hdrCnt;
		next_pos = pos;
		next_pre = pre;
		next_tgtEnd = tgtEnd;
		next_total = total;
		next_len = len;
		next_measCnt = measCnt;
		next_txReg = txReg;
		next_rxReg = rxReg;
		next_found = found;
		next_respValid = 1'b0;
		next_respData = respData;
		next_chainDevices = chainDevices;
		next_chainIrTotal = chainIrTotal;
		next_analyseOk = analyseOk;
		userScan = (kind == KIND_IR || kind == KIND_DR);
		inTarget = (pos >= pre) && (pos < tgtEnd);
		unique case (state)
			ST_RESET: begin
				if (tckRise) begin
					next_hdrCnt = hdrCnt + 3'h1;
					if (hdrCnt == `TLR_BITS - 3'h1) begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_IDLE: begin
				if (cmdValid && cmdReady && tckFall) begin
					next_state = ST_HEAD;
					next_hdrCnt = '0;
					next_pos = '0;
					next_found = 1'b0;
					next_len = cmdLen;
					next_txReg = cmdData;
					next_rxReg = '0;
					if (cmdKind == KIND_IR) begin
						next_kind = KIND_IR;
						next_pre = cfg.preIr;
						next_tgtEnd = cfg.preIr + cmdLen;
						next_total = cfg.preIr + cmdLen + cfg.postIr;
					end else if (cmdKind == KIND_DR) begin
						next_kind = KIND_DR;
						next_pre = cfg.preDr;
						next_tgtEnd = cfg.preDr + cmdLen;
						next_total = cfg.preDr + cmdLen + cfg.postDr;
					end else begin
						next_kind = KIND_AIR;
						next_pre = `FLUSH_BITS;
						next_tgtEnd = `FLUSH_BITS;
						next_total = `ANALYSE_BITS;
					end
				end
			end
			ST_HEAD: begin
				if (tckRise) begin
					next_hdrCnt = hdrCnt + 3'h1;
					if (hdrCnt == headLen(kind) - 3'h1) begin
						next_state = ST_SHIFT;
						next_pos = '0;
					end
				end
			end
			ST_SHIFT: begin
				if (tckRise) begin
					next_pos = pos + `CNT_W'(1);
					if (userScan) begin
						if (inTarget) begin
							next_txReg = txReg >> 1;
							next_rxReg = {tdoIn, rxReg[MAX_DR-1:1]};
						end
						if (pos == total - `CNT_W'(1)) begin
							next_state = ST_EXIT;
						end
					end else if (found || pos == total - `CNT_W'(1)) begin
						next_state = ST_EXIT;
					end else if (pos >= pre && tdoIn) begin
						next_found = 1'b1;
						next_measCnt = pos - pre;
					end
				end
			end
			ST_EXIT: begin
				if (tckRise) begin
					next_state = ST_UPDATE;
				end
			end
			ST_UPDATE: begin
				if (tckRise) begin
					if (kind == KIND_AIR) begin
						next_chainIrTotal = found ? measCnt : '0;
						next_kind = KIND_ADR;
						next_state = ST_HEAD;
						next_hdrCnt = '0;
						next_pos = '0;
						next_found = 1'b0;
					end else begin
						next_state = ST_IDLE;
						next_respValid = 1'b1;
						if (kind == KIND_ADR) begin
							next_chainDevices = found ? measCnt : '0;
							next_analyseOk = found && measCnt != '0 && chainIrTotal != '0;
						end else begin
							next_respData = rxReg >> (`CNT_W'(MAX_DR) - len);
						end
					end
				end
			end
		endcase
		next_cmdReady = (next_state == ST_IDLE);
	end

	// TMS and TDI change on falling TCK for the coming rise
	always_comb begin
		next_tms = tms;
		next_tdi = tdi;
		nextInTarget = (next_pos >= next_pre) && (next_pos < next_tgtEnd);
		if (tckFall) begin
			next_tdi = 1'b1;
			unique case (next_state)
				ST_RESET: next_tms = 1'b1;
				ST_IDLE: next_tms = 1'b0;
				ST_HEAD: next_tms = headTms(next_kind)[next_hdrCnt[1:0]];
				ST_SHIFT: begin
					next_tms = (next_pos == next_total - `CNT_W'(1)) || next_found;
					if (next_kind == KIND_IR) begin
						next_tdi = nextInTarget ? next_txReg[0] : `IR_PAD_BIT;
					end else if (next_kind == KIND_DR) begin
						next_tdi = nextInTarget ? next_txReg[0] : `DR_PAD_BIT;
					end else begin
						next_tdi = (next_pos >= next_pre);
					end
				end
				ST_EXIT: next_tms = 1'b1;
				ST_UPDATE: next_tms = 1'b0;
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= ST_RESET;
			kind <= KIND_IR;
			hdrCnt <= '0;
			pos <= '0;
			pre <= '0;
			tgtEnd <= '0;
			total <= '0;
			len <= '0;
			measCnt <= '0;
			txReg <= '0;
			rxReg <= '0;
			found <= 1'b0;
			tms <= 1'b1;
			tdi <= 1'b1;
			cmdReady <= 1'b0;
			respValid <= 1'b0;
			respData <= '0;
			chainDevices <= '0;
			chainIrTotal <= '0;
			analyseOk <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			hdrCnt <= next_hdrCnt;
			pos <= next_pos;
			pre <= next_pre;
			tgtEnd <= next_tgtEnd;
			total <= next_total;
			len <= next_len;
			measCnt <= next_measCnt;
			txReg <= next_txReg;
			rxReg <= next_rxReg;
			found <= next_found;
			tms <= next_tms;
			tdi <= next_tdi;
			cmdReady <= next_cmdReady;
			respValid <= next_respValid;
			respData <= next_respData;
			chainDevices <= next_chainDevices;
			chainIrTotal <= next_chainIrTotal;
			analyseOk <= next_analyseOk;
		end
	end

	assign cfg.autoDevices = chainDevices;
	assign cfg.autoValid = analyseOk;

endmodule

//--- testbench/jtag_chain_ctrl_props.sv
`timescale 1ns/10ps
module jtag_chain_ctrl_props (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic cmdReady,
	input wire logic respValid,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic fileValid,
	input wire logic chainDescValid,
	input wire logic forceTck,
	input wire logic [5:0] forcedMhz,
	input wire logic [9:0] chainDevices,
	input wire logic [9:0] chainIrTotal,
	input wire logic analyseOk
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic prevTck;
	logic [5:0] runLen;
	logic [6:0] calm;

	// Half period in clocks for a clamped rate
	function automatic int halfOf(input int r);
		int c;
		c = (r < 1) ? 1 : (r > 6) ? 6 : r;
		return (50 + 2 * c - 1) / (2 * c);
	endfunction

	// Length of each TCK level, and how long the rate inputs stood still
	always_ff @(posedge sys_clk) begin
		prevTck <= tck;
		runLen <= (tck != prevTck) ? 6'h01 : runLen + 6'h01;
		if (srst || !$stable({forceTck, forcedMhz, fileValid, chainDescValid})) begin
			calm <= 7'h00;
		end else begin
			calm <= (calm == 7'h7f) ? calm : calm + 7'h01;
		end
	end

	sequence s_hold;
		$stable(tck) [*4];
	endsequence
	property p_reset_levels;
		disable iff (1'b0) srst |=> !tck && tms && tdi && !cmdReady && !respValid;
	endproperty
	a_reset_levels: assert property (p_reset_levels) else $error("reset levels wrong");
	property p_tms_edge;
		$changed(tms) |-> $fell(tck);
	endproperty
	a_tms_edge: assert property (p_tms_edge) else $error("tms moved off tck fall");
	property p_tdi_edge;
		$changed(tdi) |-> $fell(tck);
	endproperty
	a_tdi_edge: assert property (p_tdi_edge) else $error("tdi moved off tck fall");
	property p_resp_pulse;
		respValid |=> !respValid;
	endproperty
	a_resp_pulse: assert property (p_resp_pulse) else $error("respValid too long");
	property p_take;
		$fell(cmdReady) |-> $fell(tck) && tms;
	endproperty
	a_take: assert property (p_take) else $error("take not at tck fall with tms high");
	property p_resp_rise;
		respValid |-> $rose(tck) && !tms;
	endproperty
	a_resp_rise: assert property (p_resp_rise) else $error("answer not at tck rise to idle");
	property p_tck_min;
		$changed(tck) |=> s_hold;
	endproperty
	a_tck_min: assert property (p_tck_min) else $error("tck level too short");
	property p_tck_max;
		$changed(tck) |=> ##[0:24] $changed(tck);
	endproperty
	a_tck_max: assert property (p_tck_max) else $error("tck level too long");
	property p_rate_forced;
		$changed(tck) && forceTck && calm > 7'h3c |-> runLen == halfOf(forcedMhz);
	endproperty
	a_rate_forced: assert property (p_rate_forced) else $error("forced rate wrong");
	property p_rate_default;
		$changed(tck) && !forceTck && !fileValid && !chainDescValid && calm > 7'h3c |-> runLen == 6'h07;
	endproperty
	a_rate_default: assert property (p_rate_default) else $error("default rate wrong");
endmodule

bind jtag_chain_ctrl jtag_chain_ctrl_props props_i (.*);

//--- testbench/tap_chain_model.sv
`timescale 1ns/10ps
module tap_chain_model #(
	parameter int NDEV = 3,
	parameter int IRL [NDEV] = '{3, 5, 4}
) (
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic slow,
	output logic tdo
);
	logic [7:0] irReg [NDEV];
	logic [7:0] dataReg [NDEV];
	int st = 0;
	bit q[$];

	// TAP walk; IR states sit seven codes above DR states
	function automatic int nxt(input int s, input logic m);
		int b;
		int r;
		b = (s > 9) ? 7 : 0;
		r = s - b;
		case (s)
			0: return m ? 0 : 1;
			1: return m ? 2 : 1;
			2: return m ? 9 : 3;
			9: return m ? 0 : 10;
			default: begin
				r = (r == 8) ? (m ? 2 : 1) : (r == 5) ? (m ? 8 : 6) : (r == 6) ? (m ? 7 : 6) : (r == 7) ? (m ? 8 : 4) : (m ? 5 : 4);
				return (r < 3) ? r : r + b;
			end
		endcase
	endfunction

	// Known data contents, all devices start in bypass
	initial begin
		tdo = 1'b0;
		for (int d = 0; d < NDEV; d++) begin
			irReg[d] = 8'hff;
			dataReg[d] = 8'h5a + 8'(d * 17);
		end
	end

	// Capture, shift, update on TCK rise; device 0 nearest TDO
	always @(posedge tck) begin
		case (st)
			3, 10: begin
				q = {};
				for (int d = 0; d < NDEV; d++) begin
					if (st == 10) for (int b = 0; b < IRL[d]; b++) q.push_back(b == 0);
					else if (irReg[d] == 8'hff) q.push_back(1'b0);
					else for (int b = 0; b < 8; b++) q.push_back(dataReg[d][b]);
				end
			end
			4, 11: begin
				q.push_back(tdi);
				void'(q.pop_front());
			end
			8, 15: begin
				for (int d = 0; d < NDEV; d++) begin
					if (st == 15) for (int b = 0; b < IRL[d]; b++) irReg[d][b] = q.pop_front();
					else if (irReg[d] == 8'hff) void'(q.pop_front());
					else for (int b = 0; b < 8; b++) dataReg[d][b] = q.pop_front();
				end
			end
			0: irReg = '{default: 8'hff};
			default: ;
		endcase
		st = nxt(st, tms);
	end

	// TDO moves on TCK fall; outside shift it toggles so no stale bit passes
	always @(negedge tck) begin
		if (st == 4 || st == 11) tdo <= #(slow ? 30 : 2) q[0];
		else tdo <= #(slow ? 30 : 2) ~tdo;
	end
endmodule

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb
	import jtag_chain_pkg::*;
;
	localparam int IRL [3] = '{3, 5, 4};
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic cmdValid = 1'b0;
	scan_kind_t cmdKind = KIND_IR;
	logic [63:0] cmdData = '0;
	logic [9:0] cmdLen = 10'h001;
	logic chainDescValid = 1'b0;
	logic [3:0] devCount = 4'h3;
	logic [7:0][7:0] irLen = 64'h0000_0000_0004_0503;
	logic [3:0] targetIdx = 4'h0;
	logic fileValid = 1'b0;
	logic [7:0][5:0] freqStmt = '0;
	logic [7:0][5:0] maxFreqNote = '0;
	logic [7:0] devTargeted = 8'h07;
	logic forceTck = 1'b0;
	logic [5:0] forcedMhz = 6'h04;
	logic [9:0] opPreIr = '0;
	logic [9:0] opPostIr = '0;
	logic slow = 1'b0;
	logic cmdReady, respValid, tck, tms, tdi, tdo, analyseOk;
	logic [63:0] respData;
	logic [9:0] chainDevices, chainIrTotal;
	int nErrors = 0;
	int checked = 0;
	int cycles = 0;
	int seed = 32'h8421;

	jtag_chain_ctrl #(.MAX_DEV(8), .MAX_DR(64)) uut (.*);
	tap_chain_model #(.NDEV(3), .IRL(IRL)) partner (.*);

	initial forever #10 sys_clk = ~sys_clk;

	// Compare and count
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, nErrors);
		if (nErrors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	function automatic int halfOf(input int r);
		int c;
		c = (r < 1) ? 1 : (r > 6) ? 6 : r;
		return (50 + 2 * c - 1) / (2 * c);
	endfunction

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	// One command, held until taken, then wait for its answer
	task automatic scan(input scan_kind_t k, input logic [63:0] d, input int len);
		@(posedge sys_clk);
		cmdKind <= k;
		cmdData <= d;
		cmdLen <= 10'(len);
		cmdValid <= 1'b1;
		do tick(); while (cmdReady !== 1'b1);
		do tick(); while (cmdReady !== 1'b0);
		@(posedge sys_clk);
		cmdValid <= 1'b0;
		do tick(); while (respValid !== 1'b1);
	endtask

	// Watchdog on run length
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			nErrors++;
			tally_and_finish();
		end
	end

	initial begin
		int h, t, pre, rate, e, fr;
		int fs[3], mf[3];
		logic [7:0] tg;
		logic [63:0] d, old;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		// Rate: default, one target, several targets, forced
		for (int m = 0; m < 4; m++) begin
			@(posedge sys_clk);
			tg = (m == 1) ? 8'h01 << ($unsigned($random(seed)) % 3) : 8'h07;
			fr = 1 + $unsigned($random(seed)) % 8;
			e = 99;
			for (int i = 0; i < 3; i++) begin
				fs[i] = 1 + $unsigned($random(seed)) % 9;
				mf[i] = 1 + $unsigned($random(seed)) % 9;
				freqStmt[i] <= 6'(fs[i]);
				maxFreqNote[i] <= 6'(mf[i]);
				if (tg[i]) e = (fs[i] < e) ? fs[i] : e;
				if (tg[i]) e = (mf[i] < e) ? mf[i] : e;
			end
			devTargeted <= tg;
			fileValid <= (m != 0);
			forceTck <= (m == 3);
			forcedMhz <= 6'(fr);
			rate = (m == 0) ? 4 : (m == 3) ? fr : e;
			repeat (100) @(posedge sys_clk);
			do tick(); while (tck !== 1'b0);
			do tick(); while (tck !== 1'b1);
			h = 1;
			forever begin
				tick();
				if (tck !== 1'b1) break;
				h++;
			end
			check("tck half", h, halfOf(rate));
		end
		@(posedge sys_clk);
		// Pass 0 with a chain description, pass 1 analysed with slow TDO
		for (int pass = 0; pass < 2; pass++) begin
			@(posedge sys_clk);
			chainDescValid <= (pass == 0);
			slow <= (pass == 1);
			// Late TDO needs a longer TCK half period to settle through the synchroniser
			forcedMhz <= (pass == 1) ? 6'h04 : 6'h06;
			for (int k = 2; k < 4 && pass == 1; k++) begin
				scan(scan_kind_t'(k), 64'h0, 1);
				check("devices", chainDevices, 3);
				check("ir total", chainIrTotal, 12);
				check("analyse ok", analyseOk, 1);
			end
			for (t = 0; t < 3; t++) begin
				pre = (t > 0 ? IRL[0] : 0) + (t > 1 ? IRL[1] : 0);
				@(posedge sys_clk);
				targetIdx <= 4'(t);
				opPreIr <= 10'(pre);
				opPostIr <= 10'(12 - pre - IRL[t]);
				d = 64'($unsigned($random(seed))) & ((64'h1 << IRL[t]) - 64'h2);
				scan(KIND_IR, d, IRL[t]);
				check("ir capture", respData, 64'h1);
				for (int i = 0; i < 3; i++) begin
					check("ir held", partner.irReg[i], (i == t) ? {56'h0, 8'(8'hff << IRL[t]) | d[7:0]} : 64'hff);
				end
				old = partner.dataReg[t];
				d = 64'($unsigned($random(seed))) & 64'hff;
				scan(KIND_DR, d, 8);
				check("dr capture", respData, old);
				check("dr update", partner.dataReg[t], d);
			end
		end
		tally_and_finish();
	end
endmodule
